// ---- bench/pfl_src.sv ----
// behavioural vco and reference source that drives the pll block's two pins
// assumes the bench clock; pins change only just after a rising edge
`default_nettype none
module pfl_src (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic en_i,
   input wire logic [3:0] kdiv_i,
   input wire logic [3:0] phase_i,
   output logic vco_o,
   output logic ref_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tick_r;
   logic [3:0] edge_r;
   // each level lasts at least two clocks: the pin synchroniser needs that much
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_r <= 1'b0;
         edge_r <= 4'h0;
         vco_o <= 1'b0;
         ref_o <= 1'b0;
      end else if (en_i) begin
         tick_r <= ~tick_r;
         if (tick_r) begin
            vco_o <= ~vco_o;
            // reference rises with one vco edge in kdiv; a phase never reached stops it low
            ref_o <= !vco_o && (edge_r == phase_i);
            if (!vco_o) begin
               edge_r <= (edge_r + 4'h1 >= kdiv_i) ? 4'h0 : edge_r + 4'h1;
            end
         end
      end
   end
endmodule : pfl_src
`default_nettype wire

// ---- bench/tb_pfl_core.sv ----
// self-checking bench for pfl_core: registers, divider ratios, counter resets, lock
// assumes pfl_src on the pins; read data are checked by a monitor against a queue
`default_nettype none
module tb_pfl_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic rd_d = 1'b0;
   logic en = 1'b0;
   logic [3:0] kdiv = 4'h3;
   logic [3:0] phase = 4'h0;
   logic vco, refp, status_o, lock_o, pd_up_o, pd_dn_o, fb_div_o, ref_div_o;
   logic [7:0] rdata_o;
   logic [7:0] exp_q[$];
   logic [7:0] regs [9] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
   logic [7:0] msk [9] = '{8'h3f, 8'hff, 8'h1f, 8'h3c, 8'h03, 8'h5c, 8'h3f, 8'hff, 8'h63};
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int a, b, n, c;
   always #4 clock_i = ~clock_i;
   pfl_src src (.clock_i(clock_i), .rst_b_i(rst_b_i), .en_i(en), .kdiv_i(kdiv), .phase_i(phase),
      .vco_o(vco), .ref_o(refp));
   pfl_core dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .vco_feedback_input_i(vco), .reference_input_i(refp),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .status_o(status_o),
      .lock_o(lock_o), .pd_up_o(pd_up_o), .pd_dn_o(pd_dn_o), .fb_div_o(fb_div_o), .ref_div_o(ref_div_o));
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // read data stand only in the cycle after the strobe
   always @(posedge clock_i) begin
      rd_d <= rd_i;
      cyc <= cyc + 1;
      if (rd_d && exp_q.size() > 0) begin
         chk(rdata_o, exp_q.pop_front());
      end
      if (cyc == 60000) begin
         fail_count++;
         summarize();
      end
   end
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clock_i);
      addr_i <= ad;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clock_i);
      addr_i <= ad;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
   endtask : rd
   // cycles up to the next divider pulse, bounded so a dead divider cannot hang
   task automatic nxt(input bit sel, output int cnt);
      cnt = 0;
      do begin
         @(posedge clock_i);
         cnt++;
      end while (((sel ? ref_div_o : fb_div_o) !== 1'b1) && cnt < 2000);
   endtask : nxt
   // first periods after a change may be short, so only the third is judged
   task automatic per(input bit sel, input int m);
      int k;
      nxt(sel, k);
      nxt(sel, k);
      nxt(sel, k);
      chk(k, m * 4);
   endtask : per
   task automatic quiet(input bit r);
      int k;
      k = 0;
      // the write lands one edge late and a pulse already launched may still show
      repeat (2) @(posedge clock_i);
      repeat (150) begin
         @(posedge clock_i);
         if (fb_div_o === 1'b1 || (r && ref_div_o === 1'b1)) begin
            k++;
         end
      end
      chk(k, 0);
   endtask : quiet
   initial begin
      a = $urandom(73);
      repeat (3) @(posedge clock_i);
      rst_b_i <= 1'b1;
      foreach (regs[i]) rd(regs[i], 8'h00);
      foreach (regs[i]) wr(regs[i], 8'hff);
      foreach (regs[i]) rd(regs[i], msk[i]);
      wr(8'h07, 8'hff);
      wr(pfl_pkg::A_LOCK_ST, 8'hff);
      rd(8'h07, 8'h00);
      rd(pfl_pkg::A_LOCK_ST, 8'h00);
      foreach (regs[i]) wr(regs[i], 8'h00);
      en <= 1'b1;
      quiet(1'b0);
      a = $urandom % 4;
      b = 3 + $urandom % 4;
      wr(pfl_pkg::A_SWALLOW, 8'(a));
      wr(pfl_pkg::A_MAIN_LO, 8'(b));
      for (int m = 0; m < 8; m++) begin
         wr(pfl_pkg::A_PRESC, 8'(m << 2));
         n = (m == 0) ? b : (m == 1) ? 2 * b : (m == 7) ? 3 * b : (2 << (m - 2)) * b + a;
         per(1'b0, n);
      end
      wr(pfl_pkg::A_PRESC, 8'h44);
      per(1'b0, 2);
      per(1'b1, 3);
      wr(pfl_pkg::A_REF_LO, 8'h02);
      per(1'b1, 6);
      wr(pfl_pkg::A_REF_LO, 8'h00);
      wr(pfl_pkg::A_PRESC, 8'h00);
      wr(pfl_pkg::A_MAIN_LO, 8'h03);
      for (int k = 0; k < 2; k++) begin
         wr(pfl_pkg::A_CNT_RST, 8'(1 << k));
         quiet(k == 0);
         wr(pfl_pkg::A_CNT_RST, 8'h00);
      end
      per(1'b0, 3);
      // only one of three reference phases lines up with the feedback edge
      for (int w = 0; w < 2; w++) begin
         wr(pfl_pkg::A_LOCK_CTL, 8'(w << 5));
         n = 0;
         for (int p = 0; p < 3; p++) begin
            phase <= 4'(p);
            repeat (80) @(posedge clock_i);
            if (lock_o === 1'b1) begin
               n++;
               c = p;
            end
         end
         chk(n, 1);
      end
      phase <= 4'(c);
      repeat (80) @(posedge clock_i);
      for (int s = 0; s < 3; s++) begin
         wr(pfl_pkg::A_STAT_SEL, 8'(s << 2));
         repeat (4) @(posedge clock_i);
         chk(status_o, s == 1);
      end
      wr(pfl_pkg::A_STAT_SEL, 8'h04);
      phase <= 4'hf;
      repeat (80) @(posedge clock_i);
      rd(pfl_pkg::A_LOCK_ST, 8'h0d);
      // reference gone: down stays set, up stays clear
      chk({pd_up_o, pd_dn_o}, 2'h1);
      for (int s = 5; s < 7; s++) begin
         wr(pfl_pkg::A_STAT_SEL, 8'(s << 2));
         repeat (4) @(posedge clock_i);
         chk(status_o, s == 6);
      end
      wr(pfl_pkg::A_LOCK_CTL, 8'h40);
      repeat (3) @(posedge clock_i);
      chk(lock_o, 1'b0);
      repeat (5) @(posedge clock_i);
      summarize();
   end
endmodule : tb_pfl_core
`default_nettype wire

// ---- design/pfl_core.sv ----
// pll feedback divider, reference divider, phase detector and digital lock detector
// assumes vco and reference pins far slower than the 125 MHz clock; both pass two flops
`default_nettype none
// Contract
// - feedback divider is a 3-bit-coded prescaler, 6-bit swallow and 13-bit main counter.
// - prescaler offers dual-modulus P or P+1, and fixed-divide with three ratios.
// - codes 000, 001, 111 select fixed divide by 1, 2 and 3.
// - in fixed-divide mode the swallow counter is unused.
// - bypass bit makes main counter divide by 1; software uses it in fixed-divide only.
// - main count valid 3 to 8191; resets to invalid 0, software must program it.
// - swallow and main counters have a test reset and the shared counter reset.
// - dual-modulus ratio is P times main count plus swallow count.
// - fixed-divide ratio is fixed prescaler ratio times main count.
// - phase detector compares reference and feedback outputs into up and down pulses.
// - 2-bit antibacklash code sets minimum pulse width; code 00 gives 1.3 ns.
// - 4-bit select chooses which internal signal drives the status output.
// - with lock selected the status output is logic level, high or low active.
// - window 0: lock sets within 9.5 ns coincidence, clears at 15 ns separation.
// - window 1: lock sets at 3.5 ns coincidence, clears at 7 ns separation.
// - lock-detect disable bit turns the lock indication off.
// - lock indication need not fall when the reference stops.
// - reference divider is 14 bits, 1 to 16383, zero divides by one.
// - only the vco feedback input clocks the feedback divider.
module pfl_core #(
   parameter int SEP_W = 8
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic vco_feedback_input_i,
   input wire logic reference_input_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic status_o,
   output logic lock_o,
   output logic pd_up_o,
   output logic pd_dn_o,
   output logic fb_div_o,
   output logic ref_div_o
);
   if (SEP_W < 4 || SEP_W > 16) begin : g_chk
      $error("pfl_core: SEP_W must lie in 4..16");
   end

   // ***************************
   // decode helpers
   // ***************************
   function automatic logic is_dual(input logic [2:0] code);
      return !(code == pfl_pkg::PM_FD1 || code == pfl_pkg::PM_FD2 || code == pfl_pkg::PM_FD3);
   endfunction : is_dual

   function automatic logic [5:0] presc_mod(input logic [2:0] code, input logic plus);
      unique case (code)
         pfl_pkg::PM_FD1: return 6'h01;
         pfl_pkg::PM_FD2: return 6'h02;
         pfl_pkg::PM_FD3: return 6'h03;
         default: return (6'h01 << (code - 3'h1)) + {5'h00, plus};
      endcase
   endfunction : presc_mod

   function automatic logic [2:0] abp_cycles(input logic [1:0] code);
      unique case (code)
         2'h0: return 3'(pfl_pkg::ABP0_CYC);
         2'h1: return 3'(pfl_pkg::ABP1_CYC);
         2'h2: return 3'(pfl_pkg::ABP2_CYC);
         2'h3: return 3'(pfl_pkg::ABP3_CYC);
      endcase
   endfunction : abp_cycles

   // ***************************
   // pin synchronisers
   // ***************************
   logic [2:0] vco_sync_r;
   logic [2:0] ref_sync_r;
   logic vco_edge;
   logic ref_edge;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         vco_sync_r <= 3'h0;
         ref_sync_r <= 3'h0;
      end else begin
         vco_sync_r <= {vco_sync_r[1:0], vco_feedback_input_i};
         ref_sync_r <= {ref_sync_r[1:0], reference_input_i};
      end
   end
   // stage 0 is read by stage 1 only
   assign vco_edge = vco_sync_r[1] & ~vco_sync_r[2];
   assign ref_edge = ref_sync_r[1] & ~ref_sync_r[2];

   // ***************************
   // register file
   // ***************************
   logic [pfl_pkg::SWAL_W-1:0] swal_r;
   logic [pfl_pkg::MAIN_W-1:0] main_r;
   logic [pfl_pkg::REF_W-1:0] ref_div_r;
   logic [pfl_pkg::SEL_W-1:0] sel_r;
   logic [pfl_pkg::PRESC_W-1:0] presc_r;
   logic [pfl_pkg::ABP_W-1:0] abp_r;
   logic rst_sh_r;
   logic rst_ab_r;
   logic byp_r;
   logic win_r;
   logic lddis_r;
   logic [7:0] rd_val;
   logic [7:0] rdata_r;
   logic lock_r;
   logic up_r;
   logic dn_r;
   logic status_r;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         swal_r <= pfl_pkg::SWAL_W'(pfl_pkg::REG_RST);
         main_r <= pfl_pkg::MAIN_W'(pfl_pkg::REG_RST);
         ref_div_r <= pfl_pkg::REF_W'(pfl_pkg::REG_RST);
         sel_r <= pfl_pkg::SEL_LOW;
         presc_r <= pfl_pkg::PM_FD1;
         abp_r <= pfl_pkg::ABP_W'(pfl_pkg::REG_RST);
         rst_sh_r <= 1'b0;
         rst_ab_r <= 1'b0;
         byp_r <= 1'b0;
         win_r <= 1'b0;
         lddis_r <= 1'b0;
      end else if (wr_i) begin
         unique case (addr_i)
            pfl_pkg::A_SWALLOW: swal_r <= wdata_i[pfl_pkg::SWAL_W-1:0];
            pfl_pkg::A_MAIN_LO: main_r[pfl_pkg::LO_W-1:0] <= wdata_i;
            pfl_pkg::A_MAIN_HI: main_r[pfl_pkg::MAIN_W-1:pfl_pkg::LO_W] <= wdata_i[pfl_pkg::MAIN_W-pfl_pkg::LO_W-1:0];
            pfl_pkg::A_STAT_SEL: sel_r <= wdata_i[pfl_pkg::SEL_LSB+:pfl_pkg::SEL_W];
            pfl_pkg::A_CNT_RST: begin
               rst_sh_r <= wdata_i[pfl_pkg::RST_SH_BIT];
               rst_ab_r <= wdata_i[pfl_pkg::RST_AB_BIT];
            end
            pfl_pkg::A_PRESC: begin
               presc_r <= wdata_i[pfl_pkg::PRESC_LSB+:pfl_pkg::PRESC_W];
               byp_r <= wdata_i[pfl_pkg::BYP_BIT];
            end
            pfl_pkg::A_REF_HI: ref_div_r[pfl_pkg::REF_W-1:pfl_pkg::LO_W] <= wdata_i[pfl_pkg::REF_W-pfl_pkg::LO_W-1:0];
            pfl_pkg::A_REF_LO: ref_div_r[pfl_pkg::LO_W-1:0] <= wdata_i;
            pfl_pkg::A_LOCK_CTL: begin
               abp_r <= wdata_i[pfl_pkg::ABP_LSB+:pfl_pkg::ABP_W];
               win_r <= wdata_i[pfl_pkg::WIN_BIT];
               lddis_r <= wdata_i[pfl_pkg::LDDIS_BIT];
            end
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_val = pfl_pkg::REG_RST;
      unique case (addr_i)
         pfl_pkg::A_SWALLOW: rd_val[pfl_pkg::SWAL_W-1:0] = swal_r;
         pfl_pkg::A_MAIN_LO: rd_val = main_r[pfl_pkg::LO_W-1:0];
         pfl_pkg::A_MAIN_HI: rd_val[pfl_pkg::MAIN_W-pfl_pkg::LO_W-1:0] = main_r[pfl_pkg::MAIN_W-1:pfl_pkg::LO_W];
         pfl_pkg::A_STAT_SEL: rd_val[pfl_pkg::SEL_LSB+:pfl_pkg::SEL_W] = sel_r;
         pfl_pkg::A_CNT_RST: begin
            rd_val[pfl_pkg::RST_SH_BIT] = rst_sh_r;
            rd_val[pfl_pkg::RST_AB_BIT] = rst_ab_r;
         end
         pfl_pkg::A_PRESC: begin
            rd_val[pfl_pkg::PRESC_LSB+:pfl_pkg::PRESC_W] = presc_r;
            rd_val[pfl_pkg::BYP_BIT] = byp_r;
         end
         pfl_pkg::A_REF_HI: rd_val[pfl_pkg::REF_W-pfl_pkg::LO_W-1:0] = ref_div_r[pfl_pkg::REF_W-1:pfl_pkg::LO_W];
         pfl_pkg::A_REF_LO: rd_val = ref_div_r[pfl_pkg::LO_W-1:0];
         pfl_pkg::A_LOCK_CTL: begin
            rd_val[pfl_pkg::ABP_LSB+:pfl_pkg::ABP_W] = abp_r;
            rd_val[pfl_pkg::WIN_BIT] = win_r;
            rd_val[pfl_pkg::LDDIS_BIT] = lddis_r;
         end
         pfl_pkg::A_LOCK_ST: rd_val[3:0] = {status_r, dn_r, up_r, lock_r};
         default: rd_val = pfl_pkg::REG_RST;
      endcase
   end

   // read data are valid only in the cycle after the read strobe
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r <= pfl_pkg::REG_RST;
      end else begin
         rdata_r <= rd_i ? rd_val : pfl_pkg::REG_RST;
      end
   end

   // ***************************
   // feedback divider, clocked by vco edges only
   // ***************************
   logic [5:0] pcnt_r;
   logic [pfl_pkg::SWAL_W-1:0] acnt_r;
   logic [pfl_pkg::MAIN_W-1:0] mcnt_r;
   logic [pfl_pkg::MAIN_W-1:0] b_eff;
   logic [5:0] pmod;
   logic dual;
   logic plus;
   logic pre_tick;
   logic fb_tick;
   logic hold_fb;

   assign hold_fb = rst_sh_r | rst_ab_r;
   assign dual = is_dual(presc_r);
   assign plus = dual && (acnt_r < swal_r);
   assign pmod = presc_mod(presc_r, plus);
   // >= rather than == so a reprogrammed smaller ratio cannot run the counters away
   // a held divider must not tick, even at an overall ratio of one
   assign pre_tick = vco_edge && !hold_fb && (pcnt_r >= pmod - 6'h01);
   assign b_eff = byp_r ? pfl_pkg::MAIN_BYP_VAL : main_r;
   // a main count of zero never wraps, so an unprogrammed divider stays silent
   assign fb_tick = pre_tick && (b_eff != '0) && (mcnt_r >= b_eff - pfl_pkg::MAIN_BYP_VAL);

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pcnt_r <= 6'h00;
      end else if (hold_fb || pre_tick) begin
         pcnt_r <= 6'h00;
      end else if (vco_edge) begin
         pcnt_r <= pcnt_r + 6'h01;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acnt_r <= '0;
      end else if (hold_fb || !dual || fb_tick) begin
         acnt_r <= '0;
      end else if (pre_tick && plus) begin
         acnt_r <= acnt_r + pfl_pkg::SWAL_W'(1);
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mcnt_r <= '0;
      end else if (hold_fb || fb_tick) begin
         mcnt_r <= '0;
      end else if (pre_tick) begin
         mcnt_r <= mcnt_r + pfl_pkg::MAIN_BYP_VAL;
      end
   end

   // ***************************
   // reference divider
   // ***************************
   logic [pfl_pkg::REF_W-1:0] rcnt_r;
   logic [pfl_pkg::REF_W-1:0] r_eff;
   logic ref_tick;

   assign r_eff = (ref_div_r == '0) ? pfl_pkg::REF_ZERO_VAL : ref_div_r;
   assign ref_tick = ref_edge && !rst_sh_r && (rcnt_r >= r_eff - pfl_pkg::REF_ZERO_VAL);

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rcnt_r <= '0;
      end else if (rst_sh_r || ref_tick) begin
         rcnt_r <= '0;
      end else if (ref_edge) begin
         rcnt_r <= rcnt_r + pfl_pkg::REF_ZERO_VAL;
      end
   end

   // ***************************
   // phase detector
   // ***************************
   logic [2:0] ab_cnt_r;
   logic both;
   logic clr;
   logic up_nxt;
   logic dn_nxt;

   assign both = up_r & dn_r;
   assign clr = both && (ab_cnt_r >= abp_cycles(abp_r) - 3'h1);
   // a new edge in the clearing cycle wins over the clear
   assign up_nxt = ref_tick | (up_r & ~clr);
   assign dn_nxt = fb_tick | (dn_r & ~clr);

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         up_r <= 1'b0;
         dn_r <= 1'b0;
         ab_cnt_r <= 3'h0;
      end else begin
         up_r <= up_nxt;
         dn_r <= dn_nxt;
         ab_cnt_r <= (both && !clr) ? ab_cnt_r + 3'h1 : 3'h0;
      end
   end

   // ***************************
   // digital lock detector
   // ***************************
   logic [SEP_W-1:0] sep_r;
   logic [SEP_W-1:0] pair_sep;
   logic [SEP_W-1:0] in_cyc;
   logic [SEP_W-1:0] out_cyc;
   logic one_side;
   logic pair_evt;

   assign one_side = up_r ^ dn_r;
   assign pair_evt = up_nxt & dn_nxt & ~both;
   assign pair_sep = !one_side ? '0 : ((&sep_r) ? sep_r : sep_r + SEP_W'(1));
   assign in_cyc = win_r ? SEP_W'(pfl_pkg::LOCK_IN1_CYC) : SEP_W'(pfl_pkg::LOCK_IN0_CYC);
   assign out_cyc = win_r ? SEP_W'(pfl_pkg::LOCK_OUT1_CYC) : SEP_W'(pfl_pkg::LOCK_OUT0_CYC);

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sep_r <= '0;
      end else begin
         sep_r <= one_side ? pair_sep : '0;
      end
   end

   // no pair event while the reference is gone, so lock simply holds
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lock_r <= 1'b0;
      end else if (lddis_r) begin
         lock_r <= 1'b0;
      end else if (pair_evt && pair_sep >= out_cyc) begin
         lock_r <= 1'b0;
      end else if (pair_evt && pair_sep <= in_cyc) begin
         lock_r <= 1'b1;
      end
   end

   // ***************************
   // status multiplexer and outputs
   // ***************************
   logic fb_tick_r;
   logic ref_tick_r;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_r <= 1'b0;
         fb_tick_r <= 1'b0;
         ref_tick_r <= 1'b0;
      end else begin
         fb_tick_r <= fb_tick;
         ref_tick_r <= ref_tick;
         unique case (sel_r)
            pfl_pkg::SEL_LOCK_HI: status_r <= lock_r;
            pfl_pkg::SEL_LOCK_LO: status_r <= ~lock_r;
            pfl_pkg::SEL_REF_DIV: status_r <= ref_tick;
            pfl_pkg::SEL_FB_DIV: status_r <= fb_tick;
            pfl_pkg::SEL_PD_UP: status_r <= up_r;
            pfl_pkg::SEL_PD_DN: status_r <= dn_r;
            default: status_r <= 1'b0;
         endcase
      end
   end

   assign rdata_o = rdata_r;
   assign status_o = status_r;
   assign lock_o = lock_r;
   assign pd_up_o = up_r;
   assign pd_dn_o = dn_r;
   assign fb_div_o = fb_tick_r;
   assign ref_div_o = ref_tick_r;

   // ***************************
   // assertions
   // ***************************
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_held;
      (rcnt_r == '0) && (mcnt_r == '0) && (pcnt_r == 6'h00);
   endsequence
   property p_shared_hold;
      rst_sh_r [*2] |-> s_held;
   endproperty
   a_shared_hold: assert property (p_shared_hold) else $error("counters not held by shared reset");
   property p_ld_off;
      lddis_r |=> !lock_r;
   endproperty
   a_ld_off: assert property (p_ld_off) else $error("lock shown while disabled");
   property p_stat_hi;
      sel_r == pfl_pkg::SEL_LOCK_HI |=> status_o == $past(lock_r);
   endproperty
   a_stat_hi: assert property (p_stat_hi) else $error("status not lock active high");
   property p_stat_lo;
      sel_r == pfl_pkg::SEL_LOCK_LO |=> status_o != $past(lock_r);
   endproperty
   a_stat_lo: assert property (p_stat_lo) else $error("status not lock active low");
   property p_fd_swal;
      !dual |=> acnt_r == '0;
   endproperty
   a_fd_swal: assert property (p_fd_swal) else $error("swallow moved in fixed divide");
   property p_zero_main;
      (main_r == '0) && !byp_r |=> !fb_div_o;
   endproperty
   a_zero_main: assert property (p_zero_main) else $error("output with zero main count");
   property p_bypass;
      byp_r && pre_tick && !hold_fb |-> fb_tick ##1 fb_div_o;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass did not divide by one");
   property p_up_set;
      ref_tick |=> up_r ##0 pd_up_o;
   endproperty
   a_up_set: assert property (p_up_set) else $error("reference edge lost in detector");
   property p_lock_in0;
      pair_evt && !win_r && !lddis_r && pair_sep <= SEP_W'(pfl_pkg::LOCK_IN0_CYC) |=> lock_o;
   endproperty
   a_lock_in0: assert property (p_lock_in0) else $error("lock not set inside window 0");
   property p_lock_out1;
      pair_evt && win_r && pair_sep >= SEP_W'(pfl_pkg::LOCK_OUT1_CYC) |=> !lock_o;
   endproperty
   a_lock_out1: assert property (p_lock_out1) else $error("lock not cleared outside window 1");
   property p_abp0;
      $rose(both) && abp_r == 2'h0 && !ref_tick && !fb_tick |=> !both;
   endproperty
   a_abp0: assert property (p_abp0) else $error("antibacklash width wrong for code 0");
endmodule : pfl_core
`default_nettype wire

// ---- shared/pfl_pkg.sv ----
// constants for the pll feedback divider, phase detector and lock detector
// assumes one 125 MHz system clock and an 8-bit register port
`default_nettype none
package pfl_pkg;
   // ***************************
   // register byte addresses
   // ***************************
   localparam logic [7:0] A_SWALLOW = 8'h04;
   localparam logic [7:0] A_MAIN_LO = 8'h05;
   localparam logic [7:0] A_MAIN_HI = 8'h06;
   localparam logic [7:0] A_STAT_SEL = 8'h08;
   localparam logic [7:0] A_CNT_RST = 8'h09;
   localparam logic [7:0] A_PRESC = 8'h0a;
   localparam logic [7:0] A_REF_HI = 8'h0b;
   localparam logic [7:0] A_REF_LO = 8'h0c;
   localparam logic [7:0] A_LOCK_CTL = 8'h0d;
   localparam logic [7:0] A_LOCK_ST = 8'h0e;
   localparam logic [7:0] REG_RST = 8'h00;
   // ***************************
   // field layout
   // ***************************
   localparam int SWAL_W = 6;
   localparam int MAIN_W = 13;
   localparam int REF_W = 14;
   localparam int LO_W = 8;
   localparam int SEL_LSB = 2;
   localparam int SEL_W = 4;
   localparam int RST_SH_BIT = 0;
   localparam int RST_AB_BIT = 1;
   localparam int PRESC_LSB = 2;
   localparam int PRESC_W = 3;
   localparam int BYP_BIT = 6;
   localparam int ABP_LSB = 0;
   localparam int ABP_W = 2;
   localparam int WIN_BIT = 5;
   localparam int LDDIS_BIT = 6;
   localparam logic [MAIN_W-1:0] MAIN_BYP_VAL = 13'h0001;
   localparam logic [REF_W-1:0] REF_ZERO_VAL = 14'h0001;
   // ***************************
   // prescaler codes and status select codes
   // ***************************
   localparam logic [2:0] PM_FD1 = 3'h0;
   localparam logic [2:0] PM_FD2 = 3'h1;
   localparam logic [2:0] PM_FD3 = 3'h7;
   localparam logic [3:0] SEL_LOW = 4'h0;
   localparam logic [3:0] SEL_LOCK_HI = 4'h1;
   localparam logic [3:0] SEL_LOCK_LO = 4'h2;
   localparam logic [3:0] SEL_REF_DIV = 4'h3;
   localparam logic [3:0] SEL_FB_DIV = 4'h4;
   localparam logic [3:0] SEL_PD_UP = 4'h5;
   localparam logic [3:0] SEL_PD_DN = 4'h6;
   // ***************************
   // timing, in picoseconds, and derived cycle counts
   // ***************************
   localparam int CLK_PS = 8000;
   localparam int ABP0_PS = 1300;
   localparam int ABP1_PS = 2900;
   localparam int ABP2_PS = 6000;
   localparam int ABP3_PS = 1300;
   localparam int LOCK_IN0_PS = 9500;
   localparam int LOCK_OUT0_PS = 15000;
   localparam int LOCK_IN1_PS = 3500;
   localparam int LOCK_OUT1_PS = 7000;
   // least times round up, longest times round down, never below one cycle
   localparam int ABP0_CYC = (ABP0_PS + CLK_PS - 1) / CLK_PS;
   localparam int ABP1_CYC = (ABP1_PS + CLK_PS - 1) / CLK_PS;
   localparam int ABP2_CYC = (ABP2_PS + CLK_PS - 1) / CLK_PS;
   localparam int ABP3_CYC = (ABP3_PS + CLK_PS - 1) / CLK_PS;
   localparam int LOCK_IN0_CYC = (LOCK_IN0_PS / CLK_PS < 1) ? 1 : LOCK_IN0_PS / CLK_PS;
   localparam int LOCK_IN1_CYC = (LOCK_IN1_PS / CLK_PS < 1) ? 1 : LOCK_IN1_PS / CLK_PS;
   localparam int LOCK_OUT0_CYC = (LOCK_OUT0_PS + CLK_PS - 1) / CLK_PS;
   localparam int LOCK_OUT1_CYC = (LOCK_OUT1_PS + CLK_PS - 1) / CLK_PS;
endpackage : pfl_pkg
`default_nettype wire
